// ==== include/cmp_regs_consts.vh ====
// Offsets, field positions, reset values and codes of the comparator register bank
`ifndef CMP_REGS_CONSTS_VH
`define CMP_REGS_CONSTS_VH
`define OFS_CONFIGURATION    12'h00c
`define OFS_OUTPUT_CONTROL   12'h010
`define OFS_INPUT_SELECT     12'h014
`define OFS_STATUS           12'h018
`define CFG_BIAS_LSB         0
`define CFG_BIAS_MSB         2
`define CFG_HYSTERESIS_SELECT_LSB         8
`define CFG_HYSTERESIS_SELECT_MSB         11
`define CFG_RANGE_BIT        16
`define CFG_ACCURACY_BIT     17
`define CFG_BIAS_RESET       3'h4
`define CFG_HYSTERESIS_SELECT_RESET       4'h0
`define CTL_UNREADY_BIT      0
`define CTL_INVERT_BIT       1
`define INS_POS_LSB          0
`define INS_POS_MSB          7
`define INS_NEG_LSB          8
`define INS_NEG_MSB          15
`define INS_DIV_LSB          16
`define INS_DIV_MSB          21
`define INS_RES_LSB          28
`define INS_RES_MSB          30
`define DIV_FULL_SCALE       6'h3f
`define STS_OUT_BIT          0
`define STS_READY_BIT        2
`define STS_CONFLICT_BIT     3
`define SEL_GROUND           8'h00
`define SEL_REF_FIRST        8'h10
`define SEL_REF_LAST         8'h15
`define SEL_SENSE_FIRST      8'h20
`define SEL_SENSE_LAST       8'h23
`define SEL_TOUCH            8'h30
`define SEL_CONV_FIRST       8'h40
`define SEL_CONV_LAST        8'h41
`define SEL_EXT_FIRST        8'h50
`define SEL_EXT_LAST         8'h53
`define SEL_PIN_FIRST        8'h80
`define SEL_PIN_LAST         8'hbf
`define HYSTERESIS_SELECT_OFF             2'h0
`define HYSTERESIS_SELECT_SYM             2'h1
`define HYSTERESIS_SELECT_RISE            2'h2
`define HYSTERESIS_SELECT_FALL            2'h3
`endif

// ==== sim/comparator_config_regs_properties.sv ====
// Port-level assertions for the comparator register bank
`timescale 1ns/10ps
module comparator_config_regs_properties (
  input wire       ref_clk,                 // Bus clock
  input wire       reset,                   // Sync reset
  input wire       core_result,             // Raw comparison
  input wire       core_ready,              // Core ready
  input wire [2:0] bias_level,              // Bias level
  input wire [1:0] hysteresis_select_mode,               // Hysteresis mode
  input wire [1:0] hysteresis_select_level,              // Hysteresis level
  input wire [5:0] reference_divide_factor, // Divide factor
  input wire [7:0] positive_input_select,   // Positive code
  input wire [7:0] negative_input_select,   // Negative code
  input wire [2:0] pos_kind,                // Positive class
  input wire [5:0] pos_index,               // Positive index
  input wire       pos_low_power,           // Positive low power
  input wire [2:0] neg_kind,                // Negative class
  input wire       comparator_out,          // Conditioned output
  input wire       illegal_input_pair       // Conflict status
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Decode updates on the same edge as the register copy; judge it only once the code has held
  sequence pos_settled;
    $stable(positive_input_select) ##1 $stable(positive_input_select);
  endsequence
  sequence neg_settled;
    $stable(negative_input_select) ##1 $stable(negative_input_select);
  endsequence
  AST_RESET_BIAS: assert property ($fell(reset) |-> bias_level == 3'h4 && hysteresis_select_mode == 2'h0)
    else $error("bias or hysteresis not at reset value");
  AST_RESET_INPUTS: assert property ($fell(reset) |->
    {reference_divide_factor, positive_input_select, negative_input_select} == 22'h0)
    else $error("input select not grounded after reset");
  AST_HYSTERESIS_SELECT_LEVEL: assert property ((hysteresis_select_mode == 2'h0) == (hysteresis_select_level == 2'h0))
    else $error("hysteresis level disagrees with mode");
  AST_PIN_KIND: assert property (pos_settled |->
    (pos_kind == 3'h6) == (positive_input_select[7:6] == 2'b10))
    else $error("pin class wrong");
  AST_PIN_INDEX: assert property (pos_settled ##0 pos_kind == 3'h6 |->
    pos_index == positive_input_select[5:0])
    else $error("pin index wrong");
  AST_NEG_NO_EXT: assert property (neg_settled ##0 negative_input_select[7:2] == 6'h14 |->
    neg_kind == 3'h7)
    else $error("external code accepted on negative select");
  AST_LOW_POWER: assert property (pos_settled |-> pos_low_power ==
    ((pos_kind == 3'h1 || pos_kind == 3'h2) && positive_input_select[0]))
    else $error("low power flag wrong");
  AST_CONFLICT: assert property (neg_settled ##0 neg_kind == 3'h7 |-> ##[0:2] illegal_input_pair)
    else $error("conflict not flagged");
  AST_READY_PASS: assert property ((core_ready && core_result)[*5] |-> comparator_out)
    else $error("live result not passed when ready");
endmodule // comparator_config_regs_properties

bind comparator_config_regs comparator_config_regs_properties u_props (.ref_clk, .reset,
  .core_result, .core_ready, .bias_level, .hysteresis_select_mode, .hysteresis_select_level, .reference_divide_factor,
  .positive_input_select, .negative_input_select, .pos_kind, .pos_index, .pos_low_power,
  .neg_kind, .comparator_out, .illegal_input_pair);

// ==== sim/test_comparator_config_regs.sv ====
// Self-checking testbench of the comparator register bank
`timescale 1ns/10ps
`include "cmp_regs_consts.vh"
module test_comparator_config_regs;
  logic        ref_clk = 0, reset = 1, clk_en = 1, hsel = 0, hwrite = 0;
  logic        core_result = 0, core_ready = 0;
  logic [11:0] haddr = 12'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, input_range_low, accuracy_high, pos_low_power, neg_low_power;
  wire         comparator_out, pin_out, illegal_input_pair;
  wire  [2:0]  bias_level, legacy_sense_resistor, pos_kind, neg_kind;
  wire  [1:0]  hysteresis_select_mode, hysteresis_select_level;
  wire  [5:0]  reference_divide_factor, pos_index, neg_index;
  wire  [7:0]  positive_input_select, negative_input_select;
  wire         hready = hreadyout;
  int          error_cnt = 0, comparisons = 0;

  comparator_config_regs DUT (.ref_clk, .reset, .clk_en, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .core_result, .core_ready,
    .bias_level, .hysteresis_select_mode, .hysteresis_select_level, .input_range_low, .accuracy_high,
    .legacy_sense_resistor, .reference_divide_factor, .positive_input_select,
    .negative_input_select, .pos_kind, .pos_index, .pos_low_power, .neg_kind, .neg_index,
    .neg_low_power, .comparator_out, .pin_out, .illegal_input_pair);

  always #12.5 ref_clk = ~ref_clk;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One AHB single transfer; read data is taken at the data-phase edge
  task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= wr;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  // Outputs trail the register by a cycle plus decode
  task settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  task reset_values;
    rdchk(`OFS_CONFIGURATION, 32'h4);
    rdchk(`OFS_OUTPUT_CONTROL, 32'h0);
    rdchk(`OFS_INPUT_SELECT, 32'h0);
    chk({bias_level, hresp}, 4'h8);
  endtask
  task unmapped;
    wr(12'h020, 32'hffff_ffff);
    rdchk(12'h020, 32'h0);
  endtask
  task hysteresis_select_codes;
    logic [3:0] c;
    for (int i = 0; i < 11; i++) begin
      if (i == 7) continue;
      c = i[3:0];
      // Bits 7:3 are always written as zero
      wr(`OFS_CONFIGURATION, {14'h0, 2'b11, 4'h0, c, 5'h0, c[2:0]});
      rdchk(`OFS_CONFIGURATION, {14'h0, 2'b11, 4'h0, c, 5'h0, c[2:0]});
      settle;
      chk(hysteresis_select_mode, (c == 0) ? 2'h0 : (c < 4) ? 2'h1 : (c < 7) ? 2'h2 : 2'h3);
      chk(hysteresis_select_level, (c == 0) ? 4'h0 : (c < 4) ? c : (c < 7) ? c - 4'h3 : c - 4'h7);
      chk({bias_level, input_range_low, accuracy_high}, {c[2:0], 2'b11});
    end
  endtask
  task inputs;
    wr(`OFS_INPUT_SELECT, 32'h603f_13bf);
    rdchk(`OFS_INPUT_SELECT, 32'h603f_13bf);
    settle;
    chk({legacy_sense_resistor, reference_divide_factor}, 9'h1bf);
    chk({pos_kind, pos_index, neg_kind, neg_index, neg_low_power}, 19'h6fc83);
    wr(`OFS_INPUT_SELECT, 32'h0000_5052);
    settle;
    chk({pos_kind, pos_index, neg_kind, illegal_input_pair}, 13'h142f);
    wr(`OFS_INPUT_SELECT, 32'h0000_8585);
    settle;
    chk(illegal_input_pair, 1'b1);
    wr(`OFS_INPUT_SELECT, 32'h0000_2123);
    settle;
    chk({pos_kind, pos_index, pos_low_power, neg_kind, neg_index}, 19'h20680);
    chk({neg_low_power, illegal_input_pair}, 2'b10);
    wr(`OFS_INPUT_SELECT, 32'h0000_3041);
    settle;
    chk({pos_kind, pos_index, neg_kind}, 12'h80b);
  endtask
  task output_cond;
    wr(`OFS_OUTPUT_CONTROL, 32'h1);
    settle;
    chk({comparator_out, pin_out}, 2'b11);
    wr(`OFS_OUTPUT_CONTROL, 32'h3);
    settle;
    chk({comparator_out, pin_out}, 2'b10);
    @(posedge ref_clk);
    core_ready <= 1'b1;
    core_result <= 1'b1;
    repeat (6) @(posedge ref_clk);
    core_result <= 1'b0;
    #1;
    chk({comparator_out, pin_out}, 2'b10);
    repeat (5) @(posedge ref_clk);
    #1;
    chk({comparator_out, pin_out}, 2'b01);
    rdchk(`OFS_OUTPUT_CONTROL, 32'h3);
  endtask
  task freeze;
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(`OFS_OUTPUT_CONTROL, 32'h0);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rdchk(`OFS_OUTPUT_CONTROL, 32'h3);
  endtask

  task summarize;
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    reset_values;
    unmapped;
    hysteresis_select_codes;
    inputs;
    output_cond;
    freeze;
    summarize;
  end
  // The sequence needs well under a thousand cycles
  initial begin
    #(25 * 3000);
    error_cnt++;
    summarize;
  end
endmodule // test_comparator_config_regs

// ==== verilog/comparator_config_regs.v ====
// Configuration, output control and input select registers of the analog comparator
// Summary of operation
// - Hysteresis code 0 off, 1-3 symmetric, 4-6 rising, 8-10 falling, 10/20/30 mV.
// - Hysteresis select sits in configuration bits 11:8, resets zero, read/write.
// - Bias in configuration bits 2:0 resets to 4, read/write, drives bias level.
// - Control bit 1 inverts the result toward the pin alternate function.
// - While comparator not ready, output takes control bit 0 value.
// - Input bits 30:28 hold legacy sense resistor choice 0 to 6.
// - Six-bit divide in bits 21:16 scales reference by value over 63.
// - Negative select decodes ground, references, sense, touch and converter outputs.
// - Codes 128 to 191 map to port A to D pins in blocks of sixteen.
// - Positive select swaps touch for external interface codes 80 to 83 for ports A-D.
// - Odd codes 17, 19, 21, 33, 35 choose the low-power variant.
// - Divide and both selects reset to zero, grounding both inputs.
// - An illegal positive and negative pair raises the input conflict status.
`timescale 1ns/10ps
module comparator_config_regs (
  input  wire        ref_clk,            // 40 MHz bus clock
  input  wire        reset,              // Synchronous reset, active high
  input  wire        clk_en,             // Freezes all state while low
  input  wire        hsel,               // AHB-Lite slave select
  input  wire [11:0] haddr,              // AHB-Lite byte address
  input  wire [1:0]  htrans,             // AHB-Lite transfer type
  input  wire        hwrite,             // AHB-Lite write
  input  wire [2:0]  hsize,              // AHB-Lite transfer size
  input  wire [31:0] hwdata,             // AHB-Lite write data
  input  wire        hready,             // AHB-Lite bus ready
  output reg  [31:0] hrdata,             // AHB-Lite read data
  output wire        hreadyout,          // AHB-Lite slave ready
  output wire        hresp,              // AHB-Lite response, always OKAY
  input  wire        core_result,        // Raw comparison from the analog core (async)
  input  wire        core_ready,         // Analog core ready after warmup (async)
  output reg  [2:0]  bias_level,         // Bias current level to the core
  output reg  [1:0]  hysteresis_select_mode,          // 0 off, 1 symmetric, 2 rising, 3 falling
  output reg  [1:0]  hysteresis_select_level,         // 1..3 for 10/20/30 mV, 0 when off
  output reg         input_range_low,    // Reduced input range setting
  output reg         accuracy_high,      // High accuracy setting
  output reg  [2:0]  legacy_sense_resistor,   // Legacy sense resistor choice
  output reg  [5:0]  reference_divide_factor, // Reference scale numerator over 63
  output reg  [7:0]  positive_input_select,   // Positive mux code
  output reg  [7:0]  negative_input_select,   // Negative mux code
  output reg  [2:0]  pos_kind,           // Decoded positive source class
  output reg  [5:0]  pos_index,          // Decoded positive source index
  output reg         pos_low_power,      // Positive source low-power variant
  output reg  [2:0]  neg_kind,           // Decoded negative source class
  output reg  [5:0]  neg_index,          // Decoded negative source index
  output reg         neg_low_power,      // Negative source low-power variant
  output reg         comparator_out,     // Conditioned comparator output
  output reg         pin_out,            // Output to the pin alternate function
  output reg         illegal_input_pair  // Input conflict status
);
`include "cmp_regs_consts.vh"
  localparam [1:0] HTRANS_NONSEQ = 2'h2;
  localparam [1:0] HTRANS_SEQ    = 2'h3;

  reg  [2:0]  bias_q;
  reg  [3:0]  hysteresis_select_q;
  reg         range_q;
  reg         accuracy_q;
  reg         invert_q;
  reg         unready_q;
  reg  [2:0]  resistor_q;
  reg  [5:0]  divide_q;
  reg  [7:0]  negative_input_select_q;
  reg  [7:0]  positive_input_select_q;
  reg  [1:0]  result_sync_q;
  reg  [1:0]  ready_sync_q;
  reg         wr_pend_q;
  reg  [11:0] wr_addr_q;
  wire        result_s = result_sync_q[1];
  wire        ready_s  = ready_sync_q[1];
  wire        valid_xfer;
  wire [2:0]  pk;
  wire [5:0]  pi;
  wire        pl;
  wire [2:0]  nk;
  wire [5:0]  ni;
  wire        nl;

  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign valid_xfer = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  // Hysteresis code to mode and level; unlisted codes fall back to off
  function [3:0] hysteresis_select_decode;
    input [3:0] code;
    begin
      if (code >= 4'h1 && code <= 4'h3)
        hysteresis_select_decode = {`HYSTERESIS_SELECT_SYM, code[1:0]};
      else if (code >= 4'h4 && code <= 4'h6)
        hysteresis_select_decode = {`HYSTERESIS_SELECT_RISE, code[1:0] + 2'h1};
      else if (code >= 4'h8 && code <= 4'ha)
        hysteresis_select_decode = {`HYSTERESIS_SELECT_FALL, code[1:0] + 2'h1};
      else
        hysteresis_select_decode = {`HYSTERESIS_SELECT_OFF, 2'h0};
    end
  endfunction

  // Read data mux, unused bits read zero
  function [31:0] read_word;
    input [11:0] a;
    begin
      read_word = 32'h0000_0000;
      if (a == `OFS_CONFIGURATION) begin
        read_word[`CFG_BIAS_MSB:`CFG_BIAS_LSB] = bias_q;
        read_word[`CFG_HYSTERESIS_SELECT_MSB:`CFG_HYSTERESIS_SELECT_LSB] = hysteresis_select_q;
        read_word[`CFG_RANGE_BIT]              = range_q;
        read_word[`CFG_ACCURACY_BIT]           = accuracy_q;
      end else if (a == `OFS_OUTPUT_CONTROL) begin
        read_word[`CTL_UNREADY_BIT] = unready_q;
        read_word[`CTL_INVERT_BIT]  = invert_q;
      end else if (a == `OFS_INPUT_SELECT) begin
        read_word[`INS_POS_MSB:`INS_POS_LSB] = positive_input_select_q;
        read_word[`INS_NEG_MSB:`INS_NEG_LSB] = negative_input_select_q;
        read_word[`INS_DIV_MSB:`INS_DIV_LSB] = divide_q;
        read_word[`INS_RES_MSB:`INS_RES_LSB] = resistor_q;
      end else if (a == `OFS_STATUS) begin
        read_word[`STS_OUT_BIT]      = comparator_out;
        read_word[`STS_READY_BIT]    = ready_s;
        read_word[`STS_CONFLICT_BIT] = illegal_input_pair;
      end
    end
  endfunction

  input_code_decode u_pos_decode (
    .code         (positive_input_select_q),
    .positive     (1'b1),
    .source_kind  (pk),
    .source_index (pi),
    .low_power    (pl)
  );

  input_code_decode u_neg_decode (
    .code         (negative_input_select_q),
    .positive     (1'b0),
    .source_kind  (nk),
    .source_index (ni),
    .low_power    (nl)
  );

  // Address phase captured; write data lands in the following cycle
  always @(posedge ref_clk) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      hrdata    <= 32'h0000_0000;
    end else if (clk_en) begin
      wr_pend_q <= valid_xfer && hwrite;
      if (valid_xfer) begin
        wr_addr_q <= haddr;
      end
      if (valid_xfer && !hwrite) begin
        hrdata <= read_word({haddr[11:2], 2'b00});
      end
    end
  end

  // Register writes; bits 7:3 of configuration are not stored, software keeps them zero
  always @(posedge ref_clk) begin
    if (reset) begin
      bias_q     <= `CFG_BIAS_RESET;
      hysteresis_select_q     <= `CFG_HYSTERESIS_SELECT_RESET;
      range_q    <= 1'b0;
      accuracy_q <= 1'b0;
      invert_q   <= 1'b0;
      unready_q  <= 1'b0;
      resistor_q <= 3'h0;
      divide_q   <= 6'h00;
      negative_input_select_q   <= 8'h00;
      positive_input_select_q   <= 8'h00;
    end else if (clk_en && wr_pend_q) begin
      if (wr_addr_q[11:2] == `OFS_CONFIGURATION >> 2) begin
        bias_q     <= hwdata[`CFG_BIAS_MSB:`CFG_BIAS_LSB];
        hysteresis_select_q     <= hwdata[`CFG_HYSTERESIS_SELECT_MSB:`CFG_HYSTERESIS_SELECT_LSB];
        range_q    <= hwdata[`CFG_RANGE_BIT];
        accuracy_q <= hwdata[`CFG_ACCURACY_BIT];
      end else if (wr_addr_q[11:2] == `OFS_OUTPUT_CONTROL >> 2) begin
        invert_q  <= hwdata[`CTL_INVERT_BIT];
        unready_q <= hwdata[`CTL_UNREADY_BIT];
      end else if (wr_addr_q[11:2] == `OFS_INPUT_SELECT >> 2) begin
        // Ordering against the module enable is up to software
        resistor_q <= hwdata[`INS_RES_MSB:`INS_RES_LSB];
        divide_q   <= hwdata[`INS_DIV_MSB:`INS_DIV_LSB];
        negative_input_select_q   <= hwdata[`INS_NEG_MSB:`INS_NEG_LSB];
        positive_input_select_q   <= hwdata[`INS_POS_MSB:`INS_POS_LSB];
      end
    end
  end

  // Core signals are asynchronous to the bus clock
  always @(posedge ref_clk) begin
    if (reset) begin
      result_sync_q <= 2'b00;
      ready_sync_q  <= 2'b00;
    end else if (clk_en) begin
      result_sync_q <= {result_sync_q[0], core_result};
      ready_sync_q  <= {ready_sync_q[0], core_ready};
    end
  end

  // Registered outputs toward the analog core and the pin
  always @(posedge ref_clk) begin
    if (reset) begin
      bias_level              <= `CFG_BIAS_RESET;
      hysteresis_select_mode               <= `HYSTERESIS_SELECT_OFF;
      hysteresis_select_level              <= 2'h0;
      input_range_low         <= 1'b0;
      accuracy_high           <= 1'b0;
      legacy_sense_resistor   <= 3'h0;
      reference_divide_factor <= 6'h00;
      positive_input_select   <= 8'h00;
      negative_input_select   <= 8'h00;
      pos_kind                <= 3'h0;
      pos_index               <= 6'h00;
      pos_low_power           <= 1'b0;
      neg_kind                <= 3'h0;
      neg_index               <= 6'h00;
      neg_low_power           <= 1'b0;
      comparator_out          <= 1'b0;
      pin_out                 <= 1'b0;
      illegal_input_pair      <= 1'b0;
    end else if (clk_en) begin
      bias_level              <= bias_q;
      {hysteresis_select_mode, hysteresis_select_level} <= hysteresis_select_decode(hysteresis_select_q);
      input_range_low         <= range_q;
      accuracy_high           <= accuracy_q;
      legacy_sense_resistor   <= resistor_q;
      reference_divide_factor <= divide_q;
      positive_input_select   <= positive_input_select_q;
      negative_input_select   <= negative_input_select_q;
      pos_kind                <= pk;
      pos_index               <= pi;
      pos_low_power           <= pl;
      neg_kind                <= nk;
      neg_index               <= ni;
      neg_low_power           <= nl;
      comparator_out          <= ready_s ? result_s : unready_q;
      pin_out                 <= (ready_s ? result_s : unready_q) ^ invert_q;
      // Same pin on both sides, or any unlisted code, is illegal
      illegal_input_pair      <= (pk == 3'h7) || (nk == 3'h7) ||
                                 (pk == 3'h6 && nk == 3'h6 && pi == ni);
    end
  end
endmodule // comparator_config_regs

// ==== verilog/input_code_decode.v ====
// Decoder of one comparator input select code into source class, index and power mode
`timescale 1ns/10ps
module input_code_decode (
  input  wire [7:0] code,        // Input select code
  input  wire       positive,    // High when decoding the positive select
  output reg  [2:0] source_kind, // 0 ground,1 ref,2 sense,3 touch,4 conv,5 ext,6 pin,7 illegal
  output reg  [5:0] source_index,// Port*16+pin, reference, sense, converter or port index
  output reg        low_power    // Low-power variant chosen
);
`include "cmp_regs_consts.vh"
  always @* begin
    source_kind  = 3'h7;
    source_index = 6'h00;
    low_power    = 1'b0;
    if (code == `SEL_GROUND) begin
      source_kind = 3'h0;
    end else if (code >= `SEL_REF_FIRST && code <= `SEL_REF_LAST) begin
      source_kind  = 3'h1;
      source_index = {4'h0, code[2:1]};
      low_power    = code[0];
    end else if (code >= `SEL_SENSE_FIRST && code <= `SEL_SENSE_LAST) begin
      source_kind  = 3'h2;
      source_index = {5'h00, code[1]};
      low_power    = code[0];
    end else if (code == `SEL_TOUCH && !positive) begin
      source_kind = 3'h3;
    end else if (code >= `SEL_CONV_FIRST && code <= `SEL_CONV_LAST) begin
      source_kind  = 3'h4;
      source_index = {5'h00, code[0]};
    end else if (code >= `SEL_EXT_FIRST && code <= `SEL_EXT_LAST && positive) begin
      source_kind  = 3'h5;
      source_index = {4'h0, code[1:0]};
    end else if (code >= `SEL_PIN_FIRST && code <= `SEL_PIN_LAST) begin
      source_kind  = 3'h6;
      source_index = code[5:0];
    end
  end
endmodule // input_code_decode
